/* File: design/hidss_consts.vh */
`ifndef HIDSS_CONSTS_VH
`define HIDSS_CONSTS_VH
// ==========================================
// Interface mode codes
`define HIDSS_MODE_NONE 3'h0
`define HIDSS_MODE_SEP_DED 3'h1
`define HIDSS_MODE_SEP_MUX 3'h2
`define HIDSS_MODE_COM_DED 3'h3
`define HIDSS_MODE_COM_MUX 3'h4
`define HIDSS_MODE_HSHAKE 3'h5
`define HIDSS_MODE_SPI 3'h6
// ==========================================
// SPI byte fields
`define HIDSS_SPI_RW_BIT 7
`define HIDSS_SPI_ADDR_HI 6
`define HIDSS_SPI_ADDR_LO 1
// ==========================================
// Reset values
`define HIDSS_ADDR_RST 6'h00
`define HIDSS_DATA_RST 8'h00
// ==========================================
// Reset phase length in ns and in cycles at 25 MHz
`define HIDSS_RESET_PHASE_NS 400
`define HIDSS_CLK_PERIOD_NS 40
`define HIDSS_RESET_PHASE_CYC ((`HIDSS_RESET_PHASE_NS + `HIDSS_CLK_PERIOD_NS - 1) / `HIDSS_CLK_PERIOD_NS)
`endif

/* File: design/hidss_spi_shift.v */
`timescale 1ns/1ps
`default_nettype none
`include "hidss_consts.vh"
// ==========================================
// SPI byte engine, mode 0, MSB first
module hidss_spi_shift (
  // Clock and reset
  input wire clk_sys,
  input wire reset,
  // Synchronised SPI pins and enable
  input wire enable,
  input wire ss_n,
  input wire sck,
  input wire mosi,
  // Read data for the address last sent
  input wire [7:0] rd_data,
  // Outputs
  output reg miso,
  output reg [5:0] reg_addr,
  output reg [7:0] wr_data,
  output reg wr_stb,
  output reg rd_stb
);
  reg sck_d;
  reg [2:0] bit_cnt;
  reg [7:0] shift_in;
  reg [7:0] shift_out;
  reg first;
  reg rd_mode;
  wire [7:0] next_byte;
  wire active;
  assign next_byte = {shift_in[6:0], mosi};
  assign active = enable & ~ss_n;
  // Frame, bit and byte handling
  always @(posedge clk_sys) begin
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
    sck_d <= sck;
    if (reset) begin
      sck_d <= 1'b0;
      bit_cnt <= 3'h0;
      shift_in <= `HIDSS_DATA_RST;
      shift_out <= `HIDSS_DATA_RST;
      first <= 1'b1;
      rd_mode <= 1'b0;
      miso <= 1'b0;
      reg_addr <= `HIDSS_ADDR_RST;
      wr_data <= `HIDSS_DATA_RST;
    end else if (!active) begin
      bit_cnt <= 3'h0;
      first <= 1'b1;
      shift_out <= `HIDSS_DATA_RST;
      miso <= 1'b0;
    end else if (sck & ~sck_d) begin
      // Rising edge samples MOSI
      shift_in <= next_byte;
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h7) begin
        if (first) begin
          first <= 1'b0;
          rd_mode <= next_byte[`HIDSS_SPI_RW_BIT];
          reg_addr <= next_byte[`HIDSS_SPI_ADDR_HI:`HIDSS_SPI_ADDR_LO];
          rd_stb <= next_byte[`HIDSS_SPI_RW_BIT];
        end else if (rd_mode) begin
          // Next address taken; end byte of zeros leaves address unchanged
          if (next_byte != 8'h00) begin
            reg_addr <= next_byte[`HIDSS_SPI_ADDR_HI:`HIDSS_SPI_ADDR_LO];
            rd_stb <= 1'b1;
          end
        end else begin
          wr_data <= next_byte;
          wr_stb <= 1'b1;
        end
      end
    end else if (~sck & sck_d) begin
      // Falling edge presents next bit
      if (bit_cnt == 3'h0) begin
        miso <= rd_mode & ~first & rd_data[7];
        shift_out <= {rd_data[6:0], 1'b0};
      end else begin
        miso <= shift_out[7];
        shift_out <= {shift_out[6:0], 1'b0};
      end
    end
  end
endmodule // hidss_spi_shift
`default_nettype wire

/* File: design/hidss_top.v */
`timescale 1ns/1ps
`default_nettype none
`include "hidss_consts.vh"
module hidss_top (
  // Clock and reset
  input wire clk_sys,
  input wire reset,
  input wire reset_powerdown_in,
  // Control pins
  input wire addr_latch,
  input wire addr_line_2,
  input wire addr_line_1,
  input wire addr_line_0_in,
  input wire read_strobe_n,
  input wire write_strobe_n,
  input wire chip_sel_n,
  // Address/data bus pins
  input wire [7:0] muxed_addr_data_bus_in,
  // Register read data from the core
  input wire [7:0] reg_rd_data,
  // Pin outputs
  output reg addr_line_0_out,
  output reg addr_line_0_oe,
  output reg miso_out,
  // Core side
  output reg [2:0] host_mode,
  output reg detect_done,
  output reg [5:0] reg_addr,
  output reg [7:0] reg_wr_data,
  output reg reg_wr_stb,
  output reg reg_rd_stb
);
  // Detection states
  localparam ST_RESET = 2'h0;
  localparam ST_PHASE = 2'h1;
  localparam ST_DETECT = 2'h2;
  localparam ST_FIXED = 2'h3;
  // Phase length from the 32-bit define, cut on purpose to the counter width
  localparam [31:0] PHASE_CYC_W = `HIDSS_RESET_PHASE_CYC;
  localparam [7:0] PHASE_CYC = PHASE_CYC_W[7:0];
  localparam NPIN = 16;
  // ==========================================
  // Two-flop synchronisers for every pin
  wire [NPIN-1:0] pin_raw;
  reg [NPIN-1:0] sync_a;
  reg [NPIN-1:0] sync_b;
  assign pin_raw = {reset_powerdown_in, addr_latch, addr_line_2, addr_line_1, addr_line_0_in,
    read_strobe_n, write_strobe_n, chip_sel_n, muxed_addr_data_bus_in};
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_sync
      always @(posedge clk_sys) begin
        if (reset) begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
        end else begin
          sync_a[gi] <= pin_raw[gi];
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate
  // Synchronised pin views
  wire s_reset_powerdown_in = sync_b[15];
  wire s_ale = sync_b[14];
  wire s_a2 = sync_b[13];
  wire s_a1 = sync_b[12];
  wire s_a0 = sync_b[11];
  wire s_rd_n = sync_b[10];
  wire s_wr_n = sync_b[9];
  wire s_cs_n = sync_b[8];
  wire [7:0] s_bus = sync_b[7:0];
  // ==========================================
  // Reset phase and detection state machine
  reg [1:0] state;
  reg [7:0] phase_cnt;
  reg reset_powerdown_in_d;
  reg ale_d;
  wire reset_powerdown_in_fall = reset_powerdown_in_d & ~s_reset_powerdown_in;
  always @(posedge clk_sys) begin
    reset_powerdown_in_d <= s_reset_powerdown_in;
    ale_d <= s_ale;
    if (reset) begin
      state <= ST_RESET;
      phase_cnt <= 8'h00;
      host_mode <= `HIDSS_MODE_NONE;
      detect_done <= 1'b0;
      reset_powerdown_in_d <= 1'b0;
      ale_d <= 1'b0;
    end else if (reset_powerdown_in_fall) begin
      // Hard reset restarts the phase
      state <= ST_PHASE;
      phase_cnt <= 8'h00;
      host_mode <= `HIDSS_MODE_NONE;
      detect_done <= 1'b0;
    end else begin
      case (state)
        ST_RESET: begin
          if (!s_reset_powerdown_in) begin
            state <= ST_PHASE;
            phase_cnt <= 8'h00;
          end
        end
        ST_PHASE: begin
          if (s_reset_powerdown_in) begin
            state <= ST_RESET;
          end else if (phase_cnt == PHASE_CYC - 8'h01) begin
            state <= ST_DETECT;
          end else begin
            phase_cnt <= phase_cnt + 8'h01;
          end
        end
        ST_DETECT: begin
          // Decide from strap levels; handshake mode also needs an ALE falling edge
          if (!s_ale & !s_a1 & !s_cs_n & s_rd_n & s_wr_n) begin
            host_mode <= `HIDSS_MODE_SPI;
            state <= ST_FIXED;
          end else if (s_a2 & s_a1 & ale_d & !s_ale) begin
            host_mode <= `HIDSS_MODE_HSHAKE;
            state <= ST_FIXED;
          end else if (!s_a2 & s_a1 & s_a0 & s_ale) begin
            host_mode <= `HIDSS_MODE_SEP_MUX;
            state <= ST_FIXED;
          end else if (!s_a2 & s_a1 & !s_a0 & s_ale) begin
            host_mode <= `HIDSS_MODE_COM_MUX;
            state <= ST_FIXED;
          end else if (s_ale & !s_rd_n & s_wr_n & !s_cs_n) begin
            host_mode <= `HIDSS_MODE_SEP_DED;
            state <= ST_FIXED;
          end else if (s_ale & !s_rd_n & !s_cs_n) begin
            host_mode <= `HIDSS_MODE_COM_DED;
            state <= ST_FIXED;
          end
        end
        default: begin
          detect_done <= 1'b1;
        end
      endcase
    end
  end
  // ==========================================
  // SPI engine
  wire spi_miso;
  wire [5:0] spi_addr;
  wire [7:0] spi_wdata;
  wire spi_wstb;
  wire spi_rstb;
  hidss_spi_shift u_spi (
    .clk_sys(clk_sys),
    .reset(reset),
    .enable(host_mode == `HIDSS_MODE_SPI),
    .ss_n(s_ale),
    .sck(s_a2),
    .mosi(s_a0),
    .rd_data(reg_rd_data),
    .miso(spi_miso),
    .reg_addr(spi_addr),
    .wr_data(spi_wdata),
    .wr_stb(spi_wstb),
    .rd_stb(spi_rstb)
  );
  // ==========================================
  // Parallel address latch, handshake wait and output muxing
  wire is_mux = (host_mode == `HIDSS_MODE_SEP_MUX) | (host_mode == `HIDSS_MODE_COM_MUX);
  wire is_hs = (host_mode == `HIDSS_MODE_HSHAKE);
  wire hs_strobe = ~s_rd_n & ~s_cs_n;
  always @(posedge clk_sys) begin
    if (reset) begin
      addr_line_0_out <= 1'b1;
      addr_line_0_oe <= 1'b0;
      miso_out <= 1'b0;
      reg_addr <= `HIDSS_ADDR_RST;
      reg_wr_data <= `HIDSS_DATA_RST;
      reg_wr_stb <= 1'b0;
      reg_rd_stb <= 1'b0;
    end else begin
      reg_wr_stb <= 1'b0;
      reg_rd_stb <= 1'b0;
      miso_out <= spi_miso;
      addr_line_0_oe <= is_hs;
      addr_line_0_out <= ~(is_hs & (~s_ale | hs_strobe));
      if (host_mode == `HIDSS_MODE_SPI) begin
        reg_addr <= spi_addr;
        reg_wr_data <= spi_wdata;
        reg_wr_stb <= spi_wstb;
        reg_rd_stb <= spi_rstb;
      end else if (is_mux & s_ale) begin
        reg_addr <= s_bus[5:0];
      end else if (is_hs & ~s_ale) begin
        // Address write only; read-address cycle not decoded
        if (!s_wr_n) begin
          reg_addr <= s_bus[5:0];
        end
      end else if (is_hs & hs_strobe & s_ale & !s_wr_n) begin
        reg_wr_data <= s_bus;
        reg_wr_stb <= 1'b1;
      end
    end
  end
endmodule // hidss_top
`default_nettype wire

/* File: tb/hidss_top_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Port checker
module hidss_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic reset_powerdown_in,
  // Pin outputs
  input wire logic addr_line_0_out,
  input wire logic addr_line_0_oe,
  // Core side
  input wire logic [2:0] host_mode,
  input wire logic detect_done,
  input wire logic reg_wr_stb,
  input wire logic reg_rd_stb
);
  default clocking @(posedge clk_sys);
  endclocking
  // Reset, phase and detection
  a_reset_clears: assert property (reset |=> !detect_done && !reg_wr_stb && !reg_rd_stb
    && host_mode == 3'h0 && addr_line_0_out && !addr_line_0_oe) else $error("bad reset");
  a_detect_wait: assert property (disable iff (reset)
    $fell(reset) |-> !detect_done [*8]) else $error("early detect");
  a_phase_wait: assert property (disable iff (reset)
    $fell(reset_powerdown_in) |-> !detect_done [*8]) else $error("early detect");
  a_done_mode: assert property (detect_done |-> host_mode != 3'h0) else $error("no mode");
  a_mode_fixed: assert property (disable iff (reset || reset_powerdown_in)
    detect_done |=> $stable(host_mode)) else $error("mode moved");
  a_wait_float: assert property (host_mode != 3'h5 |-> !addr_line_0_oe) else $error("oe");
  // Register strobes
  a_strobe_done: assert property ((reg_wr_stb || reg_rd_stb) |-> detect_done)
    else $error("early strobe");
  a_strobe_excl: assert property (!(reg_wr_stb && reg_rd_stb)) else $error("both");
  a_wr_pulse: assert property (disable iff (reset) reg_wr_stb |=> !reg_wr_stb)
    else $error("long wr");
  a_rd_pulse: assert property (disable iff (reset) reg_rd_stb |=> !reg_rd_stb)
    else $error("long rd");
endmodule // hidss_chk
`default_nettype wire

/* File: tb/hidss_spi_master.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// SPI master model
module hidss_spi_master #(
  parameter int HALF = 8
) (
  // Clock
  input wire logic clk_sys,
  // SPI pins
  output logic ss_n,
  output logic sck,
  output logic mosi,
  input wire logic miso
);
  // Idle: deselected, clock parked low
  initial begin
    ss_n = 1'b1;
    sck = 1'b0;
    mosi = 1'b1;
  end
  // One byte each way, mode 0, MSB first
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      ss_n = 1'b0;
      mosi = tx[i];
      repeat (HALF) @(negedge clk_sys);
      sck = 1'b1;
      rx[i] = miso;
      repeat (HALF) @(negedge clk_sys);
      sck = 1'b0;
    end
    repeat (2 * HALF) @(negedge clk_sys);
  endtask
  // End of frame, released line flips
  task automatic stop;
    ss_n = 1'b1;
    mosi = ~mosi;
  endtask
endmodule // hidss_spi_master
`default_nettype wire

/* File: tb/hidss_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Testbench
module hidss_top_tb;
  logic clk_sys, reset, pd, ss_n, sck, mosi, miso, done, wr_stb, rd_stb, a0_out, a0_oe;
  logic [7:0] bus = 8'h00;
  logic [7:0] rd_data = 8'h00;
  logic [7:0] wr_data;
  logic [2:0] host_mode;
  logic [5:0] reg_addr;
  logic par = 1'b0, p_ale = 1'b1, p_a2 = 1'b0, p_a0 = 1'b0;
  logic a1 = 1'b0, rd_n = 1'b1, wr_n = 1'b1, cs_n = 1'b0;
  logic [5:0] exp_addr;
  wire ale_pin = par ? p_ale : ss_n;
  wire a2_pin = par ? p_a2 : sck;
  wire a0_pin = par ? p_a0 : mosi;
  logic [13:0] wq[$];
  logic [5:0] rq[$];
  int seed = 48076;
  int error_cnt = 0;
  int samples_checked = 0;
  hidss_top i_dut (.clk_sys(clk_sys), .reset(reset), .reset_powerdown_in(pd),
    .addr_latch(ale_pin), .addr_line_2(a2_pin), .addr_line_0_in(a0_pin),
    .addr_line_1(a1), .read_strobe_n(rd_n), .write_strobe_n(wr_n), .chip_sel_n(cs_n),
    .muxed_addr_data_bus_in(bus), .reg_rd_data(rd_data), .addr_line_0_out(a0_out),
    .addr_line_0_oe(a0_oe), .miso_out(miso), .host_mode(host_mode), .detect_done(done),
    .reg_addr(reg_addr), .reg_wr_data(wr_data), .reg_wr_stb(wr_stb), .reg_rd_stb(rd_stb));
  hidss_spi_master i_master (.clk_sys(clk_sys), .ss_n(ss_n), .sck(sck), .mosi(mosi),
    .miso(miso));
  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // Core read data and floating data pins
  always @(negedge clk_sys) begin
    rd_data <= rd_fn(reg_addr);
    bus <= $random(seed);
  end
  // Strobe log
  always @(posedge clk_sys) begin
    if (wr_stb === 1'b1) wq.push_back({reg_addr, wr_data});
    if (rd_stb === 1'b1) rq.push_back(reg_addr);
  end
  function automatic logic [7:0] rd_fn(input logic [5:0] a);
    return {a[3:0], ~a[5:2]};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic results;
    if (error_cnt == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Reset, power-down pulse, then SPI detection
  task automatic detect;
    logic [7:0] rx;
    reset = 1'b1;
    repeat (8) @(negedge clk_sys);
    reset = 1'b0;
    pd = 1'b1;
    repeat (4) @(negedge clk_sys);
    pd = 1'b0;
    repeat (8) @(negedge clk_sys);
    check(16'(host_mode), 16'h0000);
    i_master.xfer(8'h00, rx);
    i_master.stop();
    repeat (8) @(negedge clk_sys);
    check(16'({a0_oe, a0_out, done, host_mode}), 16'h001E);
  endtask
  // Reset with parallel straps {ale, a2, a1, a0, rd_n, wr_n, cs_n}, then expect mode m
  task automatic par_detect(input logic [6:0] s, input logic [2:0] m);
    par = 1'b1;
    reset = 1'b1;
    {p_ale, p_a2, a1, p_a0, rd_n, wr_n, cs_n} = s;
    repeat (8) @(negedge clk_sys);
    reset = 1'b0;
    repeat (20) @(negedge clk_sys);
    if (m == 3'h5) p_ale = 1'b0;
    repeat (8) @(negedge clk_sys);
    check(16'({a0_oe, host_mode}), 16'({m == 3'h5, m}));
  endtask
  // Write and read bursts of growing length
  initial begin
    logic [5:0] al[6];
    logic [7:0] d[5];
    logic [7:0] rx;
    reset = 1'b1;
    pd = 1'b0;
    for (int r = 0; r < 2; r++) begin
      detect();
      for (int t = 0; t < 4; t++) begin
        al[0] = $random(seed);
        i_master.xfer({1'b0, al[0], 1'b0}, rx);
        for (int k = 0; k <= t; k++) begin
          d[k] = (t == 3 && k == 0) ? 8'h00 : 8'($random(seed));
          i_master.xfer(d[k], rx);
        end
        i_master.stop();
        repeat (8) @(negedge clk_sys);
        check(16'(wq.size()), 16'(t + 1));
        foreach (wq[k]) check(16'(wq[k]), {2'b00, al[0], d[k]});
        wq.delete();
        for (int k = 0; k <= t + 1; k++) begin
          al[k] = $random(seed);
          if (k > 0 && al[k] == 6'h00) al[k] = 6'h3F;
          i_master.xfer({k == 0, al[k], 1'b0}, rx);
          if (k > 0) check(16'(rx), 16'(rd_fn(al[k - 1])));
        end
        i_master.xfer(8'h00, rx);
        check(16'(rx), 16'(rd_fn(al[t + 1])));
        i_master.stop();
        repeat (8) @(negedge clk_sys);
        check(16'(rq.size()), 16'(t + 2));
        foreach (rq[k]) check(16'(rq[k]), 16'(al[k]));
        rq.delete();
      end
    end
    // Parallel hosts, strap pattern then expected mode
    par_detect(7'b1011111, 3'h2);
    @(negedge clk_sys);
    exp_addr = bus[5:0];
    p_ale = 1'b0;
    repeat (4) @(negedge clk_sys);
    check(16'(reg_addr), 16'(exp_addr));
    par_detect(7'b1010111, 3'h4);
    par_detect(7'b1100010, 3'h1);
    par_detect(7'b1100000, 3'h3);
    par_detect(7'b1110110, 3'h5);
    check(16'({a0_out, reg_addr}), 16'h0000);
    wr_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    exp_addr = bus[5:0];
    p_ale = 1'b1;
    repeat (4) @(negedge clk_sys);
    check(16'({a0_out, reg_addr}), 16'({1'b1, exp_addr}));
    results();
  end
  // Watchdog
  initial begin
    repeat (40000) @(posedge clk_sys);
    error_cnt++;
    results();
  end
endmodule // hidss_top_tb
bind hidss_top hidss_chk i_chk (.clk_sys(clk_sys), .reset(reset),
  .reset_powerdown_in(reset_powerdown_in), .addr_line_0_out(addr_line_0_out),
  .addr_line_0_oe(addr_line_0_oe), .host_mode(host_mode), .detect_done(detect_done),
  .reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb));
`default_nettype wire
